// ===== amcc_coef_store.sv
`timescale 1ns/100ps
module amcc_coef_store
    import amcc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire amcc_coef_wr_s wr_in,
    input wire logic rd_chan_in,
    input wire logic rd_full_in,
    output logic [23:0] rd_data_out
);
    logic [23:0] zero_coef [2];
    logic [23:0] full_coef [2];
    logic [23:0] next_rd_data;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    zero_coef[ch] <= AMCC_CTRL_RESET;
                    full_coef[ch] <= AMCC_CTRL_RESET;
                end else if (wr_in.chan == 1'(ch)) begin
                    if (wr_in.zero_we) begin
                        zero_coef[ch] <= wr_in.zero_data;
                    end
                    if (wr_in.full_we) begin
                        full_coef[ch] <= wr_in.full_data;
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        next_rd_data = rd_full_in ? full_coef[rd_chan_in] : zero_coef[rd_chan_in];
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_data_out <= AMCC_CTRL_RESET;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end
endmodule // amcc_coef_store

// ===== amcc_control.sv
// Summary of operation
// - 24-bit control word: mode, gain, channel, flags high; 12-bit notch code low.
// - mode 000 reads conversion result with select high; mode resets to 000.
// - mode 001 self-calibrates zero and full scale, then mode returns to 000.
// - data-ready low signals completion of every calibration type except background (mode 101).
// - mode 010 calibrates system zero-scale only, flags data-ready, returns to normal.
// - mode 011 calibrates system full-scale only, flags data-ready, returns to normal.
// - mode 100 system offset: zero on input, full on reference, then normal.
// - mode 101 background calibration updates coefficients; word rate divided by six.
// - mode 110 routes select-high reads and writes to zero-scale coefficient.
// - mode 111 routes select-high reads and writes to full-scale coefficient.
// - coefficient transfers are always 24 bits regardless of word length bit.
// - coefficient writes shorter than 24 bits are discarded.
// - gain code n selects gain two to the n; reset gain is one.
// - calibrations and coefficient accesses use the selected channel's own set.
// - select-low transfers access control word; short writes are not loaded.
// - serial clocks after the 24th in a write frame are ignored.
// - data-ready falls on new word, rises after a full word is read.
`timescale 1ns/100ps
module amcc_control
    import amcc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic serial_clock_in,
    input wire logic sdata_in,
    input wire logic transmit_frame_n_in,
    input wire logic receive_frame_n_in,
    input wire logic register_select_line_in,
    input wire logic conv_valid_in,
    input wire logic [23:0] conv_word_in,
    input wire logic cal_done_in,
    input wire logic [23:0] cal_zero_in,
    input wire logic [23:0] cal_full_in,
    output logic sdata_out,
    output logic sdata_oe_out,
    output logic data_ready_n_out,
    output amcc_ctrl_s ctrl_out,
    output logic [7:0] gain_factor_out,
    output logic cal_active_out
);
    logic [AMCC_PIN_COUNT-1:0] pin_raw;
    logic [AMCC_PIN_COUNT-1:0] sync1;
    logic [AMCC_PIN_COUNT-1:0] sync2;
    logic [AMCC_PIN_COUNT-1:0] sync3;
    logic [AMCC_PIN_COUNT-1:0] pin_acc;
    logic [AMCC_PIN_COUNT-1:0] pin_chg;
    amcc_ctrl_s ctrl, next_ctrl;
    amcc_xfer_e xfer, next_xfer;
    amcc_target_e target, next_target;
    logic [23:0] shreg, next_shreg;
    logic [4:0] bitcnt, next_bitcnt;
    logic [4:0] rd_len, next_rd_len;
    logic [23:0] conv_word, next_conv_word;
    logic [2:0] bg_cnt, next_bg_cnt;
    logic dready_n, next_dready_n;
    logic sd_out, next_sd_out;
    logic sd_oe, next_sd_oe;
    logic [7:0] gain_factor, next_gain_factor;
    logic cal_active, next_cal_active;
    amcc_coef_wr_s coef_wr;
    logic [23:0] coef_rd;
    logic sclk_rise, sclk_fall, tfs_fall, tfs_rise, rfs_fall, rfs_rise;
    logic coef_mode;
    logic host_commit;
    assign pin_raw = {register_select_line_in, receive_frame_n_in, transmit_frame_n_in,
                      sdata_in, serial_clock_in};
    // pins come from the host's clock; accept a change only once stages two and three agree
    genvar p;
    generate
        for (p = 0; p < AMCC_PIN_COUNT; p++) begin : g_pin
            always_comb begin
                pin_chg[p] = (sync2[p] == sync3[p]) && (sync3[p] != pin_acc[p]);
            end
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    sync1[p] <= 1'b1;
                    sync2[p] <= 1'b1;
                    sync3[p] <= 1'b1;
                    pin_acc[p] <= 1'b1;
                end else begin
                    sync1[p] <= pin_raw[p];
                    sync2[p] <= sync1[p];
                    sync3[p] <= sync2[p];
                    pin_acc[p] <= pin_chg[p] ? sync3[p] : pin_acc[p];
                end
            end
        end
    endgenerate

    always_comb begin
        sclk_rise = pin_chg[AMCC_PIN_SCLK] && sync3[AMCC_PIN_SCLK];
        sclk_fall = pin_chg[AMCC_PIN_SCLK] && !sync3[AMCC_PIN_SCLK];
        tfs_fall = pin_chg[AMCC_PIN_TFS] && !sync3[AMCC_PIN_TFS];
        tfs_rise = pin_chg[AMCC_PIN_TFS] && sync3[AMCC_PIN_TFS];
        rfs_fall = pin_chg[AMCC_PIN_RFS] && !sync3[AMCC_PIN_RFS];
        rfs_rise = pin_chg[AMCC_PIN_RFS] && sync3[AMCC_PIN_RFS];
        coef_mode = (ctrl.mode_sel == AMCC_MODE_RW_ZERO) ||
                    (ctrl.mode_sel == AMCC_MODE_RW_FULL);
    end

    amcc_coef_store u_coef_store (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .wr_in(coef_wr),
        .rd_chan_in(ctrl.channel_select),
        .rd_full_in(ctrl.mode_sel[0]),
        .rd_data_out(coef_rd)
    );

    always_comb begin
        next_ctrl = ctrl;
        next_xfer = xfer;
        next_target = target;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_rd_len = rd_len;
        next_conv_word = conv_word;
        next_bg_cnt = bg_cnt;
        next_dready_n = dready_n;
        next_sd_out = sd_out;
        next_sd_oe = sd_oe;
        host_commit = 1'b0;
        coef_wr = '0;
        coef_wr.chan = ctrl.channel_select;
        coef_wr.zero_data = cal_zero_in;
        coef_wr.full_data = cal_full_in;
        // end of a data read first, so a new word in the same cycle wins
        if (xfer == AMCC_XF_READ && sclk_fall && bitcnt + 5'h1 == rd_len &&
            target == AMCC_TGT_DATA) begin
            next_dready_n = 1'b1;
        end
        // conversion and calibration engine events
        if (cal_done_in) begin
            unique case (ctrl.mode_sel)
                AMCC_MODE_SELF, AMCC_MODE_SYS_OFS: begin
                    coef_wr.zero_we = 1'b1;
                    coef_wr.full_we = 1'b1;
                    next_ctrl.mode_sel = AMCC_MODE_NORMAL;
                    next_dready_n = 1'b0;
                end
                AMCC_MODE_SYS_ZERO: begin
                    coef_wr.zero_we = 1'b1;
                    next_ctrl.mode_sel = AMCC_MODE_NORMAL;
                    next_dready_n = 1'b0;
                end
                AMCC_MODE_SYS_FULL: begin
                    coef_wr.full_we = 1'b1;
                    next_ctrl.mode_sel = AMCC_MODE_NORMAL;
                    next_dready_n = 1'b0;
                end
                AMCC_MODE_BACKGND: begin
                    coef_wr.zero_we = 1'b1;
                    coef_wr.full_we = 1'b1;
                end
                AMCC_MODE_NORMAL, AMCC_MODE_RW_ZERO, AMCC_MODE_RW_FULL: begin
                end
            endcase
        end
        if (conv_valid_in) begin
            if (ctrl.mode_sel == AMCC_MODE_BACKGND) begin
                // one word out of every six cycles of the sequence
                next_bg_cnt = (bg_cnt == AMCC_BG_LAST) ? 3'h0 : bg_cnt + 3'h1;
                if (bg_cnt == AMCC_BG_LAST) begin
                    next_conv_word = conv_word_in;
                    next_dready_n = 1'b0;
                end
            end else if (ctrl.mode_sel == AMCC_MODE_NORMAL || coef_mode) begin
                next_conv_word = conv_word_in;
                next_dready_n = 1'b0;
            end
        end

        // serial port
        unique case (xfer)
            AMCC_XF_IDLE: begin
                next_sd_oe = 1'b0;
                if (tfs_fall) begin
                    next_xfer = AMCC_XF_WRITE;
                    next_bitcnt = 5'h0;
                    if (!sync3[AMCC_PIN_SEL]) begin
                        next_target = AMCC_TGT_CTRL;
                    end else if (coef_mode) begin
                        next_target = AMCC_TGT_COEF;
                    end else begin
                        next_target = AMCC_TGT_NONE;
                    end
                end else if (rfs_fall) begin
                    next_xfer = AMCC_XF_READ;
                    next_bitcnt = 5'h0;
                    next_sd_oe = 1'b1;
                    next_rd_len = AMCC_FULL_LEN;
                    if (!sync3[AMCC_PIN_SEL]) begin
                        next_target = AMCC_TGT_CTRL;
                        next_shreg = ctrl;
                    end else if (coef_mode) begin
                        next_target = AMCC_TGT_COEF;
                        next_shreg = coef_rd;
                    end else begin
                        next_target = AMCC_TGT_DATA;
                        next_shreg = conv_word;
                        if (!ctrl.word_length_select) begin
                            next_rd_len = AMCC_SHORT_LEN;
                        end
                    end
                    next_sd_out = next_shreg[23];
                end
            end
            AMCC_XF_WRITE: begin
                if (sclk_rise && bitcnt < AMCC_FULL_LEN) begin
                    next_shreg = {shreg[22:0], sync3[AMCC_PIN_SDATA]};
                    next_bitcnt = bitcnt + 5'h1;
                end
                if (tfs_rise) begin
                    next_xfer = AMCC_XF_IDLE;
                    if (bitcnt == AMCC_FULL_LEN) begin
                        unique case (target)
                            AMCC_TGT_CTRL: begin
                                host_commit = 1'b1;
                            end
                            AMCC_TGT_COEF: begin
                                coef_wr.zero_we = !ctrl.mode_sel[0];
                                coef_wr.full_we = ctrl.mode_sel[0];
                                coef_wr.zero_data = shreg;
                                coef_wr.full_data = shreg;
                            end
                            AMCC_TGT_DATA, AMCC_TGT_NONE: begin
                            end
                        endcase
                    end
                end
            end
            AMCC_XF_READ: begin
                if (sclk_fall && bitcnt < rd_len) begin
                    next_shreg = {shreg[22:0], 1'b0};
                    next_sd_out = shreg[22];
                    next_bitcnt = bitcnt + 5'h1;
                end
                if (rfs_rise) begin
                    next_xfer = AMCC_XF_IDLE;
                    next_sd_oe = 1'b0;
                end
            end
            default: begin
                next_xfer = AMCC_XF_IDLE;
            end
        endcase
        // host's new word overrides the automatic mode clear
        if (host_commit) begin
            next_ctrl = shreg;
            next_bg_cnt = 3'h0;
        end

        next_gain_factor = 8'h01 << next_ctrl.gain_sel;
        next_cal_active = (next_ctrl.mode_sel != AMCC_MODE_NORMAL) &&
                          (next_ctrl.mode_sel != AMCC_MODE_RW_ZERO) &&
                          (next_ctrl.mode_sel != AMCC_MODE_RW_FULL);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctrl <= AMCC_CTRL_RESET;
            xfer <= AMCC_XF_IDLE;
            target <= AMCC_TGT_NONE;
            shreg <= AMCC_CTRL_RESET;
            bitcnt <= 5'h0;
            rd_len <= AMCC_FULL_LEN;
            conv_word <= AMCC_CTRL_RESET;
            bg_cnt <= 3'h0;
            dready_n <= 1'b1;
            sd_out <= 1'b0;
            sd_oe <= 1'b0;
            gain_factor <= 8'h01;
            cal_active <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            xfer <= next_xfer;
            target <= next_target;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            rd_len <= next_rd_len;
            conv_word <= next_conv_word;
            bg_cnt <= next_bg_cnt;
            dready_n <= next_dready_n;
            sd_out <= next_sd_out;
            sd_oe <= next_sd_oe;
            gain_factor <= next_gain_factor;
            cal_active <= next_cal_active;
        end
    end

    assign ctrl_out = ctrl;
    assign data_ready_n_out = dready_n;
    assign sdata_out = sd_out;
    assign sdata_oe_out = sd_oe;
    assign gain_factor_out = gain_factor;
    assign cal_active_out = cal_active;
endmodule // amcc_control

// ===== amcc_control_asserts.sv
`timescale 1ns/100ps
module amcc_control_asserts
    import amcc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic transmit_frame_n_in,
    input wire logic receive_frame_n_in,
    input wire logic conv_valid_in,
    input wire logic cal_done_in,
    input wire logic sdata_oe_out,
    input wire logic data_ready_n_out,
    input wire amcc_ctrl_s ctrl_out,
    input wire logic [7:0] gain_factor_out,
    input wire logic cal_active_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic [2:0] mode;
    assign mode = ctrl_out.mode_sel;
    // a commit lands some clocks after the pin rises, so wait out the synchroniser
    sequence s_wr_quiet;
        transmit_frame_n_in [*8];
    endsequence
    sequence s_rd_quiet;
        receive_frame_n_in [*8];
    endsequence
    a_reset_defaults: assert property (disable iff (1'b0) rst_in |=> ctrl_out == AMCC_CTRL_RESET
        && data_ready_n_out && !sdata_oe_out && gain_factor_out == 8'h01) else $error("reset values");
    a_gain_power: assert property (gain_factor_out == (8'h01 << ctrl_out.gain_sel))
        else $error("gain factor");
    a_cal_active: assert property (cal_active_out == (mode inside {[3'h1:3'h5]}))
        else $error("cal active");
    a_cal_return: assert property (s_wr_quiet ##0 (cal_done_in && mode inside {[3'h1:3'h4]})
        |=> mode == AMCC_MODE_NORMAL && !data_ready_n_out) else $error("cal return");
    a_bg_stays: assert property (s_wr_quiet ##0 (cal_done_in && mode == AMCC_MODE_BACKGND)
        |=> mode == AMCC_MODE_BACKGND) else $error("background left");
    a_conv_ready: assert property (s_wr_quiet ##0 (conv_valid_in && mode inside {3'h0, 3'h6, 3'h7})
        |=> !data_ready_n_out) else $error("ready not low");
    a_ready_hold: assert property (s_rd_quiet ##0 !data_ready_n_out |=> !data_ready_n_out)
        else $error("ready rose unread");
    a_oe_idle: assert property (s_rd_quiet |-> !sdata_oe_out) else $error("drive outside frame");
    a_oe_start: assert property ($fell(receive_frame_n_in) && transmit_frame_n_in
        |-> ##[2:8] sdata_oe_out) else $error("no drive in frame");
endmodule // amcc_control_asserts

bind amcc_control amcc_control_asserts u_amcc_control_asserts (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .transmit_frame_n_in(transmit_frame_n_in),
    .receive_frame_n_in(receive_frame_n_in), .conv_valid_in(conv_valid_in),
    .cal_done_in(cal_done_in), .sdata_oe_out(sdata_oe_out), .data_ready_n_out(data_ready_n_out),
    .ctrl_out(ctrl_out), .gain_factor_out(gain_factor_out), .cal_active_out(cal_active_out));

// ===== amcc_host.sv
`timescale 1ns/100ps
module amcc_host (
    input wire logic clk_sys_in,
    input wire logic sdata_wire_in,
    output logic serial_clock_out,
    output logic sdata_out,
    output logic transmit_frame_n_out,
    output logic receive_frame_n_out,
    output logic register_select_line_out
);
    initial begin
        serial_clock_out = 1'b0;
        sdata_out = 1'b0;
        transmit_frame_n_out = 1'b1;
        receive_frame_n_out = 1'b1;
        register_select_line_out = 1'b0;
    end
    // clocks beyond 24 carry filler bits
    task automatic send(input logic sel, input int n, input logic [23:0] v);
        @(negedge clk_sys_in);
        register_select_line_out = sel;
        transmit_frame_n_out = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            sdata_out = (i < 24) ? v[23 - i] : i[0];
            #160 serial_clock_out = 1'b1;
            #160 serial_clock_out = 1'b0;
        end
        #160 transmit_frame_n_out = 1'b1;
        // released line shows the inverse, never a stale bit
        sdata_out = ~sdata_out;
        #400;
    endtask
    task automatic fetch(input logic sel, input int n, output logic [23:0] v);
        v = 24'h000000;
        @(negedge clk_sys_in);
        register_select_line_out = sel;
        receive_frame_n_out = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            #160 serial_clock_out = 1'b1;
            // device moves its bit on the falling edge, so take it on the rising one
            v = {v[22:0], sdata_wire_in};
            #160 serial_clock_out = 1'b0;
        end
        #160 receive_frame_n_out = 1'b1;
        #400;
    endtask
endmodule // amcc_host

// ===== amcc_pkg.sv
package amcc_pkg;
    localparam int AMCC_WORD_BITS = 24;
    localparam logic [4:0] AMCC_FULL_LEN = 5'd24;
    localparam logic [4:0] AMCC_SHORT_LEN = 5'd16;
    localparam logic [2:0] AMCC_BG_LAST = 3'd5;
    localparam logic [2:0] AMCC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] AMCC_MODE_SELF = 3'h1;
    localparam logic [2:0] AMCC_MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] AMCC_MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] AMCC_MODE_SYS_OFS = 3'h4;
    localparam logic [2:0] AMCC_MODE_BACKGND = 3'h5;
    localparam logic [2:0] AMCC_MODE_RW_ZERO = 3'h6;
    localparam logic [2:0] AMCC_MODE_RW_FULL = 3'h7;
    localparam logic [23:0] AMCC_CTRL_RESET = 24'h000000;
    localparam int AMCC_PIN_SCLK = 0;
    localparam int AMCC_PIN_SDATA = 1;
    localparam int AMCC_PIN_TFS = 2;
    localparam int AMCC_PIN_RFS = 3;
    localparam int AMCC_PIN_SEL = 4;
    localparam int AMCC_PIN_COUNT = 5;

    typedef struct packed {
        logic [2:0] mode_sel;
        logic [2:0] gain_sel;
        logic channel_select;
        logic power_down_bit;
        logic word_length_select;
        logic excitation_current_enable;
        logic burnout_current_enable;
        logic unipolar_select;
        logic [11:0] notch_code;
    } amcc_ctrl_s;

    typedef struct packed {
        logic zero_we;
        logic full_we;
        logic chan;
        logic [23:0] zero_data;
        logic [23:0] full_data;
    } amcc_coef_wr_s;

    typedef enum logic [1:0] {
        AMCC_TGT_CTRL,
        AMCC_TGT_DATA,
        AMCC_TGT_COEF,
        AMCC_TGT_NONE
    } amcc_target_e;

    typedef enum logic [1:0] {
        AMCC_XF_IDLE,
        AMCC_XF_WRITE,
        AMCC_XF_READ
    } amcc_xfer_e;
endpackage

// ===== tb.sv
`timescale 1ns/100ps
module tb;
    import amcc_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic conv_valid_in = 1'b0, cal_done_in = 1'b0;
    logic [23:0] conv_word_in = 24'h000000, cal_zero_in = 24'h000000, cal_full_in = 24'h000000;
    wire logic serial_clock, host_sdata, wr_frame_n, rd_frame_n, reg_sel, sdata_wire;
    logic sdata_out, sdata_oe_out, data_ready_n_out, cal_active_out, chan;
    amcc_ctrl_s ctrl_out;
    logic [7:0] gain_factor_out;
    int err_total = 0, checks = 0, cyc = 0;
    int unsigned seed = 29;
    logic [23:0] coef_z [2], coef_f [2], w, v, rd;
    always #20 clk_sys_in = ~clk_sys_in;
    assign sdata_wire = sdata_oe_out ? sdata_out : host_sdata;
    amcc_host u_amcc_host (.clk_sys_in(clk_sys_in), .sdata_wire_in(sdata_wire),
        .serial_clock_out(serial_clock), .sdata_out(host_sdata), .transmit_frame_n_out(wr_frame_n),
        .receive_frame_n_out(rd_frame_n), .register_select_line_out(reg_sel));
    amcc_control u_amcc_control (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .serial_clock_in(serial_clock), .sdata_in(sdata_wire), .transmit_frame_n_in(wr_frame_n),
        .receive_frame_n_in(rd_frame_n), .register_select_line_in(reg_sel),
        .conv_valid_in(conv_valid_in), .conv_word_in(conv_word_in), .cal_done_in(cal_done_in),
        .cal_zero_in(cal_zero_in), .cal_full_in(cal_full_in), .sdata_out(sdata_out),
        .sdata_oe_out(sdata_oe_out), .data_ready_n_out(data_ready_n_out), .ctrl_out(ctrl_out),
        .gain_factor_out(gain_factor_out), .cal_active_out(cal_active_out));
    function automatic logic [23:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[23:0];
    endfunction
    function automatic logic [23:0] mk(input logic [2:0] m, input logic [2:0] g, input logic c,
        input logic wide);
        logic [23:0] r;
        r = rnd();
        return {m, g, c, r[16], wide, r[14:0]};
    endfunction
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
        checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic set_ctrl(input logic [23:0] c);
        u_amcc_host.send(1'b0, 24, c);
        chk("ctrl_out", c, ctrl_out);
    endtask
    // one-cycle pulse; returns a clock and a half after the outputs respond
    task automatic pulse(input logic conv, input logic [23:0] a, input logic [23:0] b);
        @(negedge clk_sys_in);
        conv_valid_in = conv;
        cal_done_in = ~conv;
        conv_word_in = a;
        cal_zero_in = a;
        cal_full_in = b;
        @(negedge clk_sys_in);
        conv_valid_in = 1'b0;
        cal_done_in = 1'b0;
        @(negedge clk_sys_in);
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        coef_z = '{24'h000000, 24'h000000};
        coef_f = '{24'h000000, 24'h000000};
        repeat (20) @(negedge clk_sys_in);
        rst_in = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        u_amcc_host.fetch(1'b0, 24, rd);
        chk("ctrl_read", AMCC_CTRL_RESET, rd);
        for (int g = 0; g < 8; g++) begin
            w = mk(AMCC_MODE_NORMAL, g[2:0], g[0], 1'b1);
            set_ctrl(w);
            chk("gain_factor_out", 24'h000001 << g, 24'(gain_factor_out));
            u_amcc_host.fetch(1'b0, 24, rd);
            chk("ctrl_read", w, rd);
        end
        u_amcc_host.send(1'b0, 16, rnd());
        chk("ctrl_short", w, ctrl_out);
        w = mk(AMCC_MODE_NORMAL, 3'h0, 1'b0, 1'b1);
        u_amcc_host.send(1'b0, 30, w);
        chk("ctrl_long", w, ctrl_out);
        for (int k = 0; k < 2; k++) begin
            if (k == 1) set_ctrl(mk(AMCC_MODE_NORMAL, 3'h0, 1'b0, 1'b0));
            v = rnd();
            pulse(1'b1, v, 24'h000000);
            chk("data_ready_n_out", 24'h000000, 24'(data_ready_n_out));
            u_amcc_host.fetch(1'b1, 24 - 8 * k, rd);
            chk("data_read", (k == 1) ? v >> 8 : v, rd);
            chk("data_ready_n_out", 24'h000001, 24'(data_ready_n_out));
        end
        set_ctrl(mk(AMCC_MODE_BACKGND, 3'h0, 1'b0, 1'b1));
        for (int k = 1; k <= 6; k++) begin
            pulse(1'b1, rnd(), 24'h000000);
            chk("data_ready_n_out", 24'(k < 6), 24'(data_ready_n_out));
        end
        v = rnd();
        rd = rnd();
        pulse(1'b0, v, rd);
        coef_z[0] = v;
        coef_f[0] = rd;
        chk("mode_bg", 24'(AMCC_MODE_BACKGND), 24'(ctrl_out.mode_sel));
        for (int m = 1; m <= 4; m++) begin
            v = rnd();
            chan = v[0];
            w = mk(m[2:0], 3'h0, chan, 1'b0);
            set_ctrl(w);
            chk("cal_active_out", 24'h000001, 24'(cal_active_out));
            u_amcc_host.fetch(1'b1, 16, rd);
            chk("data_ready_n_out", 24'h000001, 24'(data_ready_n_out));
            v = rnd();
            rd = rnd();
            pulse(1'b0, v, rd);
            if (m != 3) coef_z[chan] = v;
            if (m != 2) coef_f[chan] = rd;
            chk("mode_sel", 24'(AMCC_MODE_NORMAL), 24'(ctrl_out.mode_sel));
            chk("data_ready_n_out", 24'h000000, 24'(data_ready_n_out));
            u_amcc_host.fetch(1'b0, 24, rd);
            chk("ctrl_read", {3'h0, w[20:0]}, rd);
        end
        for (int p = 0; p < 8; p++) begin
            set_ctrl(mk({2'b11, p[1]}, 3'h0, p[0], 1'b0));
            if (p >= 4) begin
                v = rnd();
                u_amcc_host.send(1'b1, 24, v);
                if (p[1]) coef_f[p[0]] = v;
                else coef_z[p[0]] = v;
                u_amcc_host.send(1'b1, 16, rnd());
            end
            u_amcc_host.fetch(1'b1, 24, rd);
            chk("coef_read", p[1] ? coef_f[p[0]] : coef_z[p[0]], rd);
        end
        stop_test();
    end
endmodule // tb
